/* File: hdl/rbt_transceiver.sv */
/*
  Registered 18-bit two-way transceiver, A-to-B single register,
  B-to-A single register or four-stage pipeline.
  Assumes all pins are synchronous to clock; pads resolve the enables.
  Pad drivers and bus hold sit outside; only levels and enables leave here.
*/
`timescale 1ns/1ps
module rbt_transceiver #(
  parameter int unsigned WIDTH = rbt_pkg::RBT_WIDTH
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] a_in,
  output logic [WIDTH-1:0] a_out,
  output logic [WIDTH-1:0] a_oe_n,
  input wire logic [WIDTH-1:0] b_in,
  output logic [WIDTH-1:0] b_out,
  output logic [WIDTH-1:0] b_oe_n,
  input wire logic a_to_b_clock,
  input wire logic b_to_a_first_clock,
  input wire logic b_to_a_second_clock,
  input wire logic a_to_b_clock_en_n,
  input wire logic b_to_a_clock_en_n,
  input wire logic a_to_b_drive_en_n,
  input wire logic b_to_a_drive_en_n,
  input wire logic path_single_sel
);
  // Stages that shift on the first B-to-A clock
  localparam int unsigned FIRST = rbt_pkg::RBT_FIRST_STAGES;

  // Sampled edges and enables travel from the edge finder as one bundle
  rbt_pin_if pins ();
  // Front stages; the third feeds the last register in pipeline mode
  logic [WIDTH-1:0] stage_q [FIRST];
  // Last B-to-A register, shared by both path modes
  logic [WIDTH-1:0] ba_shadow_q;

  // Pad clock levels become one-cycle strobes; a clock held high is no edge
  rbt_edge_det u_edge (
    .clock(clock),
    .reset(reset),
    .a_to_b_clock(a_to_b_clock),
    .b_to_a_first_clock(b_to_a_first_clock),
    .b_to_a_second_clock(b_to_a_second_clock),
    .a_to_b_clock_en_n(a_to_b_clock_en_n),
    .b_to_a_clock_en_n(b_to_a_clock_en_n),
    .path_single_sel(path_single_sel),
    .pins(pins.src)
  );

  // Enabled load strobes for the register logic; the checks write them out again as sequences
  function automatic logic load_ok(input logic edge_seen, input logic en_n);
    return edge_seen & ~en_n;
  endfunction

  // A-to-B register; its value drives the B pads
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      b_out <= rbt_pkg::RBT_RESET_WORD;
    end else if (load_ok(pins.ab_edge, pins.ab_en_n)) begin
      b_out <= a_in;
    end
  end // Otherwise held

  // First three pipeline stages shift on the first B-to-A clock
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < FIRST; i++) begin
        stage_q[i] <= rbt_pkg::RBT_RESET_WORD;
      end
    end else if (load_ok(pins.ba1_edge, pins.ba_en_n)) begin
      stage_q[0] <= b_in;
      for (int i = 1; i < FIRST; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  // Final register: B direct when single, else third stage
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ba_shadow_q <= rbt_pkg::RBT_RESET_WORD;
    end else if (load_ok(pins.ba2_edge, pins.ba_en_n)) begin
      ba_shadow_q <= pins.single_sel ? b_in : stage_q[FIRST-1];
    end
  end

  // Registered copy so the A pads come straight from a flip-flop
  // Costs one cycle of latency after the load strobe.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      a_out <= rbt_pkg::RBT_RESET_WORD;
    end else begin
      a_out <= ba_shadow_q;
    end
  end

  // Drivers float unless enabled; low enable means driving
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      a_oe_n <= '1;
      b_oe_n <= '1;
    end else begin
      a_oe_n <= {WIDTH{b_to_a_drive_en_n}};
      b_oe_n <= {WIDTH{a_to_b_drive_en_n}};
    end
  end

  // Helper history for checks
  logic [WIDTH-1:0] b_hist_q;
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      b_hist_q <= rbt_pkg::RBT_RESET_WORD;
    end else begin
      b_hist_q <= b_in;
    end
  end

  sequence ab_load_s;
    pins.ab_edge && !pins.ab_en_n;
  endsequence

  sequence ba2_load_s;
    pins.ba2_edge && !pins.ba_en_n;
  endsequence

  sequence ba1_load_s;
    pins.ba1_edge && !pins.ba_en_n;
  endsequence

  // Second-clock loads split by the select seen at that same edge
  sequence single_load_s;
    ba2_load_s ##0 pins.single_sel;
  endsequence

  sequence pipe_load_s;
    ba2_load_s ##0 !pins.single_sel;
  endsequence

  // A-to-B register: loads only on an enabled edge, else holds
  ab_capture_a: assert property (@(posedge clock) disable iff (reset)
    ab_load_s |=> b_out == $past(a_in)) else $error("A-to-B capture wrong");
  ab_hold_a: assert property (@(posedge clock) disable iff (reset)
    pins.ab_en_n |=> $stable(b_out)) else $error("B changed while disabled");
  ab_no_edge_a: assert property (@(posedge clock) disable iff (reset)
    !pins.ab_edge |=> $stable(b_out)) else $error("B changed without edge");
  // A pads show a load two cycles on: last register, then the pad flop
  single_path_a: assert property (@(posedge clock) disable iff (reset)
    single_load_s |=> ##1 a_out == $past(b_hist_q))
    else $error("single path value wrong");
  pipe_path_a: assert property (@(posedge clock) disable iff (reset)
    pipe_load_s |=> ##1 a_out == $past(stage_q[FIRST-1], 2))
    else $error("pipeline final stage wrong");
  // Clock enable high freezes the first front stage and the last register; the A pad flop follows a cycle later
  ba_hold_a: assert property (@(posedge clock) disable iff (reset)
    pins.ba_en_n |=> $stable(ba_shadow_q) && $stable(stage_q[0]))
    else $error("B-to-A changed while disabled");
  first_shift_a: assert property (@(posedge clock) disable iff (reset)
    pins.ba1_edge && !pins.ba_en_n |=> stage_q[0] == $past(b_in))
    else $error("first stage did not load");
  // Pad enables are plain copies, one cycle late
  b_drive_a: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> b_oe_n == {WIDTH{$past(a_to_b_drive_en_n)}})
    else $error("B enable wrong");
  a_drive_a: assert property (@(posedge clock) disable iff (reset)
    1'b1 |=> a_oe_n == {WIDTH{$past(b_to_a_drive_en_n)}})
    else $error("A enable wrong");

  // Pads float while reset is held; no disable here on purpose
  oe_reset_a: assert property (@(posedge clock)
    reset |=> a_oe_n == '1 && b_oe_n == '1)
    else $error("pads driven during reset");

  // An edge with the enable high is ignored by the A-to-B register
  ab_gate_a: assert property (@(posedge clock) disable iff (reset)
    pins.ab_edge && pins.ab_en_n |=> $stable(b_out))
    else $error("B loaded while disabled");

  // Front stages move up by one on each enabled first-clock edge
  pipe_shift_a: assert property (@(posedge clock) disable iff (reset)
    ba1_load_s |=> stage_q[1] == $past(stage_q[0]) && stage_q[2] == $past(stage_q[1]))
    else $error("pipeline stages did not shift");

  // No enabled first-clock edge, no movement in the front stages
  stage_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(pins.ba1_edge && !pins.ba_en_n) |=>
      $stable(stage_q[0]) && $stable(stage_q[1]) && $stable(stage_q[2]))
    else $error("pipeline stage moved without edge");

  // The last register answers to the second clock alone
  shadow_hold_a: assert property (@(posedge clock) disable iff (reset)
    !(pins.ba2_edge && !pins.ba_en_n) |=> $stable(ba_shadow_q))
    else $error("last register moved without edge");

  // First-clock edges alone never reach the A pads, in either mode;
  // only a second-clock load moves them, two cycles on
  a_quiet_a: assert property (@(posedge clock) disable iff (reset)
    !(pins.ba2_edge && !pins.ba_en_n) |=> ##1 $stable(a_out))
    else $error("A moved without second-clock load");

  // Two cycles of enable high leave the A pads where they were
  a_hold_a: assert property (@(posedge clock) disable iff (reset)
    pins.ba_en_n ##1 pins.ba_en_n |=> $stable(a_out))
    else $error("A changed while disabled");

  // The A-to-B clock never reaches the B-to-A registers
  ba_isolated_a: assert property (@(posedge clock) disable iff (reset)
    pins.ab_edge && !pins.ba1_edge && !pins.ba2_edge |=>
      $stable(ba_shadow_q) && $stable(stage_q[0]))
    else $error("A-to-B clock moved B-to-A path");

  // Select is only looked at on a second-clock load; changing it alone is harmless
  sel_change_a: assert property (@(posedge clock) disable iff (reset)
    $changed(pins.single_sel) && !(pins.ba2_edge && !pins.ba_en_n) |=> ##1 $stable(a_out))
    else $error("select change moved A");
endmodule // rbt_transceiver

/* File: hdl/rbt_pkg.sv */
/*
  Shared constants for the registered bus transceiver.
  Assumes a single system clock; the documented clocks arrive as sampled inputs.
*/
package rbt_pkg;
  localparam int unsigned RBT_WIDTH = 18;
  localparam int unsigned RBT_PIPE_DEPTH = 4;
  localparam int unsigned RBT_FIRST_STAGES = 3;
  localparam logic RBT_RESET_BIT = 1'h0;
  localparam logic [RBT_WIDTH-1:0] RBT_RESET_WORD = 18'h00000;
endpackage

/* File: hdl/rbt_pin_if.sv */
/*
  Bundle carrying the sampled clock edges and enables between top and core.
  Assumes edges are one-cycle pulses of the system clock.
*/
`timescale 1ns/1ps
interface rbt_pin_if;
  logic ab_edge;
  logic ba1_edge;
  logic ba2_edge;
  logic ab_en_n;
  logic ba_en_n;
  logic single_sel;
  modport src (output ab_edge, output ba1_edge, output ba2_edge,
    output ab_en_n, output ba_en_n, output single_sel);
  modport dst (input ab_edge, input ba1_edge, input ba2_edge,
    input ab_en_n, input ba_en_n, input single_sel);
endinterface

/* File: hdl/rbt_edge_det.sv */
/*
  Rising-edge detector for the three documented clock inputs.
  Assumes the inputs are synchronous to clock.
*/
`timescale 1ns/1ps
module rbt_edge_det (
  input wire logic clock,
  input wire logic reset,
  input wire logic a_to_b_clock,
  input wire logic b_to_a_first_clock,
  input wire logic b_to_a_second_clock,
  input wire logic a_to_b_clock_en_n,
  input wire logic b_to_a_clock_en_n,
  input wire logic path_single_sel,
  rbt_pin_if.src pins
);
  logic [2:0] prev_q;

  // Previous clock levels, for edge finding
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      prev_q <= '1; // A clock already high at release gives no edge
    end else begin
      prev_q <= {b_to_a_second_clock, b_to_a_first_clock, a_to_b_clock};
    end
  end

  // Low-to-high transitions only
  assign pins.ab_edge = a_to_b_clock & ~prev_q[0];
  assign pins.ba1_edge = b_to_a_first_clock & ~prev_q[1];
  assign pins.ba2_edge = b_to_a_second_clock & ~prev_q[2];
  assign pins.ab_en_n = a_to_b_clock_en_n;
  assign pins.ba_en_n = b_to_a_clock_en_n;
  assign pins.single_sel = path_single_sel;
endmodule // rbt_edge_det

/* File: bench/rbt_far_bus.sv */
/*
  Far-side bus model standing on the B port of the transceiver.
  Assumes one active-low B drive enable per bit, as the block gives.
*/
`timescale 1ns/1ps
module rbt_far_bus (
  input wire logic [rbt_pkg::RBT_WIDTH-1:0] b_out,
  input wire logic [rbt_pkg::RBT_WIDTH-1:0] b_oe_n,
  input wire logic [rbt_pkg::RBT_WIDTH-1:0] far_val,
  output logic [rbt_pkg::RBT_WIDTH-1:0] b_in
);
  // Each bit follows the block while it drives, else the far talker
  always_comb b_in = (b_out & ~b_oe_n) | (far_val & b_oe_n);
endmodule // rbt_far_bus

/* File: bench/tb_top.sv */
/*
  Self-checking bench for the registered transceiver.
  Assumes documented clocks are slow levels changed at the falling edge.
*/
`timescale 1ns/1ps
module tb_top;
  localparam int W = rbt_pkg::RBT_WIDTH;
  logic clock, reset, ab_clk, ba1, ba2, ab_en_n, ba_en_n, ab_oe_n, ba_oe_n, sel;
  logic [W-1:0] a_in, a_out, a_oe_n, b_in, b_out, b_oe_n, far_val;
  int n_mismatch, n_checks;
  int cyc = 0;
  rbt_transceiver rbt_transceiver_i (.clock(clock), .reset(reset), .a_in(a_in),
    .a_out(a_out), .a_oe_n(a_oe_n), .b_in(b_in), .b_out(b_out), .b_oe_n(b_oe_n),
    .a_to_b_clock(ab_clk), .b_to_a_first_clock(ba1), .b_to_a_second_clock(ba2),
    .a_to_b_clock_en_n(ab_en_n), .b_to_a_clock_en_n(ba_en_n),
    .a_to_b_drive_en_n(ab_oe_n), .b_to_a_drive_en_n(ba_oe_n), .path_single_sel(sel));
  rbt_far_bus rbt_far_bus_i (.b_out(b_out), .b_oe_n(b_oe_n), .far_val(far_val), .b_in(b_in));
  initial begin
    clock = 1'h0;
    forever #2.5 clock = ~clock;
  end
  // Hang guard, well beyond the roughly 75 cycles the tests need
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [W-1:0] seen, input logic [W-1:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One edge on a documented clock, then time for the A output's two stages
  task automatic pulse(ref logic c);
    @(negedge clock) c = 1'h1;
    @(negedge clock) c = 1'h0;
    repeat (3) @(negedge clock);
  endtask
  task automatic t_a_to_b();
    a_in = 18'h2A5C3;
    pulse(ab_clk);
    chk(b_out, 18'h2A5C3);
    a_in = 18'h15A3C;
    pulse(ba1);
    pulse(ba2);
    chk(b_out, 18'h2A5C3);
    ab_en_n = 1'h1;
    pulse(ab_clk);
    chk(b_out, 18'h2A5C3);
  endtask
  task automatic t_single();
    sel = 1'h1;
    far_val = 18'h3C0F1;
    pulse(ba2);
    chk(a_out, 18'h3C0F1);
    far_val = 18'h0F0F0;
    pulse(ba1);
    chk(a_out, 18'h3C0F1);
  endtask
  // Distinct words show which stage the last register loads from
  task automatic t_pipe();
    sel = 1'h0;
    for (int i = 1; i <= 3; i++) begin
      far_val = W'(i * 18'h11111);
      pulse(ba1);
      chk(a_out, 18'h3C0F1);
    end
    pulse(ba2);
    chk(a_out, 18'h11111);
    far_val = 18'h0ABCD;
    pulse(ba1);
    ba_en_n = 1'h1;
    pulse(ba2);
    chk(a_out, 18'h11111);
    ba_en_n = 1'h0;
    pulse(ba2);
    chk(a_out, 18'h22222);
  endtask
  task automatic t_drive();
    ab_oe_n = 1'h0;
    ba_oe_n = 1'h0;
    repeat (2) @(negedge clock);
    chk(b_oe_n, '0);
    chk(a_oe_n, '0);
    chk(b_in, 18'h2A5C3);
    ab_oe_n = 1'h1;
    ba_oe_n = 1'h1;
    repeat (2) @(negedge clock);
    chk(b_oe_n, '1);
    chk(a_oe_n, '1);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    {reset, ab_oe_n, ba_oe_n} = 3'h7;
    {ab_clk, ba1, ba2, ab_en_n, ba_en_n, sel} = 6'h00;
    {a_in, far_val, n_mismatch, n_checks} = '0;
    repeat (6) @(negedge clock);
    reset = 1'h0;
    chk(a_oe_n, '1);
    chk(b_out, '0);
    t_a_to_b();
    t_single();
    t_pipe();
    t_drive();
    tally_and_finish();
  end
endmodule // tb_top
